// file: pkg/tcl_cfg.svh
// Constants of the traffic channel test loop: frame sizes, codes, counts.
// Assumes nothing; included by bare name wherever a constant is needed.
`ifndef TCL_CFG_SVH
`define TCL_CFG_SVH

// Command transport: link-layer access point and its width
`define TCL_SAPI_W 4
`define TCL_SAPI_SIGNALLING 4'h0

// Frame and burst sizes in bits
`define TCL_FRAME_BITS 260
`define TCL_EFR_BITS 244
`define TCL_BURST_BITS 114
`define TCL_LEN_W 9
`define TCL_LEN_FRAME 9'h104
`define TCL_LEN_EFR 9'h0f4
`define TCL_LEN_BURST 9'h072

// Silence descriptor codes from the decoder
`define TCL_SID_ERASED 2'h0
`define TCL_SID_INVALID 2'h1
`define TCL_SID_VALID 2'h2

// Administrative data byte that marks a test card (value arbitrary)
`define TCL_ADMIN_TEST 8'h80
`define TCL_ADMIN_MASK 8'h80

// Frame counts: reporting period, setup delay, round-trip bound
`define TCL_CNT_W 7
`define TCL_REPORT_FRAMES 7'h68
`define TCL_SETUP_FRAMES 7'h01
`define TCL_RTD_MAX_FRAMES 7'h1a

`endif

// file: pkg/tcl_pkg.sv
// Types of the traffic channel test loop: commands, frames, states.
// Assumes tcl_cfg.svh is on the include path.
`include "tcl_cfg.svh"
package tcl_pkg;

  // Loop type carried by a close command
  typedef enum logic [2:0] {
    LOOP_A = 3'h0,
    LOOP_B = 3'h1,
    LOOP_C = 3'h2,
    LOOP_D = 3'h3,
    LOOP_E = 3'h4,
    LOOP_F = 3'h5
  } tcl_loop_e;

  // Kind of a received burst
  typedef enum logic [1:0] {
    BURST_TCH = 2'h0,
    BURST_SACCH = 2'h1,
    BURST_IDLE = 2'h2
  } tcl_burst_e;

  // Controller state, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_LOOP = 3'h2,
    ST_DAI = 3'h4
  } tcl_state_e;

  // Decoded layer 3 test command with its transport
  typedef struct packed {
    logic close;
    logic open;
    tcl_loop_e loop;
    logic [`TCL_SAPI_W-1:0] sapi;
    logic ack_mode;
    logic on_dcch;
  } tcl_cmd_s;

  // Downlink word: decoded frame or decrypted burst
  typedef struct packed {
    logic is_burst;
    tcl_burst_e kind;
    logic midamble_ok;
    logic efr;
    logic bfi;
    logic ufi;
    logic facch;
    logic [1:0] sid;
    logic [`TCL_FRAME_BITS-1:0] bits;
  } tcl_rx_s;

  // Uplink word toward the encoder or burst builder
  typedef struct packed {
    logic is_burst;
    logic own_midamble;
    logic [`TCL_LEN_W-1:0] nbits;
    logic [`TCL_FRAME_BITS-1:0] bits;
  } tcl_tx_s;

endpackage

// file: core/tcl_sync2.sv
// Two-stage synchroniser for a group of pin levels.
// Assumes pins are asynchronous to clk_sys; output is clean on clk_sys.
`timescale 1ns/1ps
module tcl_sync2 #(
  parameter int N = 2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Levels
  input wire logic [N-1:0] pin_in,
  output logic [N-1:0] level_out
);

  logic [N-1:0] meta_q;
  logic [N-1:0] meta_d;
  logic [N-1:0] sync_q;
  logic [N-1:0] sync_d;

  // One pair of flops per bit
  for (genvar i = 0; i < N; i++) begin : g_bit
    always_comb begin
      meta_d[i] = pin_in[i];
      sync_d[i] = meta_q[i];
    end
  end

  // Register both stages
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign level_out = sync_q;

endmodule

// file: core/tcl_pair_buf.sv
// Two-entry buffer with valid and ready on both sides and a flush.
// Assumes producer and consumer run on clk_sys; data out comes from flops.
`timescale 1ns/1ps
module tcl_pair_buf #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [W-1:0] mem_q [2];
  logic [W-1:0] mem_d [2];
  logic wr_q, wr_d, rd_q, rd_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and occupancy update; flush empties the buffer
  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (flush) begin
      wr_d = 1'b0;
      rd_d = 1'b0;
      cnt_d = 2'h0;
    end else begin
      if (push) begin
        mem_d[wr_q] = in_data;
        wr_d = ~wr_q;
      end
      if (pop) begin
        rd_d = ~rd_q;
      end
      if (push && !pop) begin
        cnt_d = cnt_q + 2'h1;
      end else if (pop && !push) begin
        cnt_d = cnt_q - 2'h1;
      end
    end
  end

  // Register buffer state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      mem_q <= mem_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

endmodule

// file: core/tcl_test_loop.sv
// Traffic channel test loop controller and loop-back datapath.
// Assumes layer 3 commands, channel state and decoder words arrive on clk_sys;
// card-present and power-off are pins. Frame ticks mark TDMA frames.
//
// Behaviour
// - Traffic loops and the digital audio test never run together.
// - Commands accepted only from dedicated channel, access point 0, acknowledged mode.
// - Power-off or card removal drops every active test function.
// - Test functions activate only with a test card inserted.
// - Test card recognised by its administrative data byte.
// - A loop is set up only while a traffic channel is active.
// - Only a close command switches a loop on; six types A to F.
// - Loop C returns the 114 decrypted information bits of each traffic channel burst.
// - Loop C returns bursts whatever the received midamble state.
// - Loop C uplink bursts carry the device's own midamble.
// - Loop C never returns control channel or idle bursts.
// - Loops A and B on enhanced full rate return 244, else 260 bits.
// - A, D, E, F signal erased, unreliable or erased descriptor frames.
// - Close command ignored without traffic channel or with a loop closed.
// - A signalled frame is sent to the encoder as all zeros.
// - Loop C runs within 104 frames of the close acknowledgement.
// - Loop C round trip stays under 26 frames; code only raises rtd_overrun after 26 frames at the buffer head.
`timescale 1ns/1ps
`include "tcl_cfg.svh"
module tcl_test_loop (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Layer 3 command
  input wire logic cmd_valid,
  input wire tcl_pkg::tcl_cmd_s cmd,
  output logic close_ack,
  // Traffic channel state and frame timing
  input wire logic tch_active,
  input wire logic frame_tick,
  // Card and power pins
  input wire logic card_present_pin,
  input wire logic power_off_pin,
  // Card administrative data
  input wire logic admin_valid,
  input wire logic [7:0] admin_data,
  // Digital audio interface test
  input wire logic dai_req,
  output logic digital_audio_test_port,
  // Downlink words
  input wire logic rx_valid,
  output logic rx_ready,
  input wire tcl_pkg::tcl_rx_s rx,
  // Uplink words
  output logic tx_valid,
  input wire logic tx_ready,
  output tcl_pkg::tcl_tx_s tx,
  // Status
  output logic loop_closed,
  output logic loop_running,
  output tcl_pkg::tcl_loop_e loop_type,
  output logic test_card,
  output logic rtd_overrun
);

  tcl_pkg::tcl_state_e st_q, st_d;
  tcl_pkg::tcl_loop_e type_q, type_d;
  logic ack_q, ack_d;
  logic card_q, card_d;
  logic run_q, run_d;
  logic [`TCL_CNT_W-1:0] est_q, est_d;
  logic [`TCL_CNT_W-1:0] age_q, age_d;
  logic ovr_q, ovr_d;
  logic [1:0] pins_sync;
  logic card_in, power_off;
  logic drop_all, cmd_ok, close_ok, open_ok;
  logic keep, zero, buf_in_ready, buf_flush;
  tcl_pkg::tcl_tx_s word;

  // Pin levels through two flops
  tcl_sync2 #(
    .N(2)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_in({power_off_pin, card_present_pin}),
    .level_out(pins_sync)
  );

  assign card_in = pins_sync[0];
  assign power_off = pins_sync[1];

  // Any power-off or missing card ends all tests
  assign drop_all = power_off || !card_in;

  // Command transport check
  assign cmd_ok = cmd_valid && cmd.on_dcch && cmd.ack_mode &&
                  (cmd.sapi == `TCL_SAPI_SIGNALLING);

  // Close taken only from idle, with channel and test card
  assign close_ok = cmd_ok && cmd.close && !cmd.open && (st_q == tcl_pkg::ST_IDLE) &&
                    tch_active && card_q && !drop_all;
  assign open_ok = cmd_ok && cmd.open && !cmd.close;

  // Test card recognition from the administrative byte
  always_comb begin
    card_d = card_q;
    if (!card_in) begin
      card_d = 1'b0;
    end else if (admin_valid) begin
      card_d = ((admin_data & `TCL_ADMIN_MASK) == `TCL_ADMIN_TEST);
    end
  end

  // Test function state machine
  always_comb begin
    st_d = st_q;
    type_d = type_q;
    ack_d = 1'b0;
    case (st_q)
      tcl_pkg::ST_IDLE: begin
        if (close_ok) begin
          st_d = tcl_pkg::ST_LOOP;
          type_d = cmd.loop;
          ack_d = 1'b1;
        end else if (dai_req && card_q && !drop_all) begin
          st_d = tcl_pkg::ST_DAI;
        end
      end
      tcl_pkg::ST_LOOP: begin
        if (drop_all) begin
          st_d = tcl_pkg::ST_IDLE;
        end else if (open_ok) begin
          st_d = tcl_pkg::ST_IDLE;
        end
      end
      tcl_pkg::ST_DAI: begin
        if (drop_all || !dai_req) begin
          st_d = tcl_pkg::ST_IDLE;
        end
      end
      default: begin
        st_d = tcl_pkg::ST_IDLE;
      end
    endcase
  end

  // Establishment: loop starts one frame after acknowledgement
  always_comb begin
    est_d = est_q;
    run_d = run_q;
    if (st_q != tcl_pkg::ST_LOOP) begin
      est_d = '0;
      run_d = 1'b0;
    end else if (!run_q && frame_tick) begin
      est_d = est_q + `TCL_CNT_W'(1);
      if ((est_q + `TCL_CNT_W'(1)) >= `TCL_SETUP_FRAMES) begin
        run_d = 1'b1;
      end
    end
  end

  // Per-type keep and erase decisions
  always_comb begin
    keep = 1'b0;
    zero = 1'b0;
    case (type_q)
      tcl_pkg::LOOP_A: begin
        keep = !rx.is_burst && !rx.facch;
        zero = rx.bfi;
      end
      tcl_pkg::LOOP_B: begin
        keep = !rx.is_burst && !rx.facch;
      end
      tcl_pkg::LOOP_C: begin
        keep = rx.is_burst && (rx.kind == tcl_pkg::BURST_TCH);
      end
      tcl_pkg::LOOP_D: begin
        keep = !rx.is_burst;
        zero = rx.bfi || rx.ufi || rx.facch;
      end
      tcl_pkg::LOOP_E: begin
        keep = !rx.is_burst;
        zero = rx.facch || (rx.sid == `TCL_SID_ERASED);
      end
      tcl_pkg::LOOP_F: begin
        keep = !rx.is_burst;
        zero = rx.facch || (rx.sid != `TCL_SID_VALID);
      end
      default: begin
        keep = 1'b0;
      end
    endcase
  end

  // Build the uplink word
  always_comb begin
    word = '0;
    word.is_burst = (type_q == tcl_pkg::LOOP_C);
    word.own_midamble = (type_q == tcl_pkg::LOOP_C);
    if (type_q == tcl_pkg::LOOP_C) begin
      word.nbits = `TCL_LEN_BURST;
      word.bits[`TCL_BURST_BITS-1:0] = rx.bits[`TCL_BURST_BITS-1:0];
    end else if (rx.efr && (type_q == tcl_pkg::LOOP_A || type_q == tcl_pkg::LOOP_B)) begin
      word.nbits = `TCL_LEN_EFR;
      word.bits[`TCL_EFR_BITS-1:0] = rx.bits[`TCL_EFR_BITS-1:0];
    end else begin
      word.nbits = `TCL_LEN_FRAME;
      word.bits = rx.bits;
    end
    if (zero) begin
      word.bits = '0;
    end
  end

  // Outside a running loop words pass to normal decoding and are not held
  assign rx_ready = (run_q && keep) ? buf_in_ready : 1'b1;
  assign buf_flush = !run_q;

  // Holding buffer toward the uplink encoder
  tcl_pair_buf #(
    .W($bits(tcl_pkg::tcl_tx_s))
  ) u_buf (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .flush(buf_flush),
    .in_valid(rx_valid && run_q && keep),
    .in_ready(buf_in_ready),
    .in_data(word),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx)
  );

  // Round-trip watch: frames a word waits at the head of the buffer
  always_comb begin
    age_d = age_q;
    ovr_d = ovr_q;
    if (close_ok) begin
      ovr_d = 1'b0;
    end
    if (!tx_valid || tx_ready) begin
      age_d = '0;
    end else if (frame_tick && (age_q != `TCL_RTD_MAX_FRAMES)) begin
      age_d = age_q + `TCL_CNT_W'(1);
    end
    if (tx_valid && (age_q == `TCL_RTD_MAX_FRAMES) && (type_q == tcl_pkg::LOOP_C)) begin
      ovr_d = 1'b1;
    end
  end

  // Register controller state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= tcl_pkg::ST_IDLE;
      type_q <= tcl_pkg::LOOP_A;
      ack_q <= 1'b0;
      card_q <= 1'b0;
      run_q <= 1'b0;
      est_q <= '0;
      age_q <= '0;
      ovr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      type_q <= type_d;
      ack_q <= ack_d;
      card_q <= card_d;
      run_q <= run_d;
      est_q <= est_d;
      age_q <= age_d;
      ovr_q <= ovr_d;
    end
  end

  // Status outputs from flops
  assign close_ack = ack_q;
  assign loop_closed = (st_q == tcl_pkg::ST_LOOP);
  assign digital_audio_test_port = (st_q == tcl_pkg::ST_DAI);
  assign loop_running = run_q;
  assign loop_type = type_q;
  assign test_card = card_q;
  assign rtd_overrun = ovr_q;

endmodule

// file: testbench/tcl_test_loop_props.sv
// Checker of the test loop ports: exclusion, command gating, formats.
// Assumes binding into tcl_test_loop; one clock, async low reset.
`timescale 1ns/1ps
`include "tcl_cfg.svh"
module tcl_test_loop_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Inputs
  input wire logic cmd_valid,
  input wire tcl_pkg::tcl_cmd_s cmd,
  input wire logic tch_active,
  input wire logic frame_tick,
  input wire logic card_present_pin,
  input wire logic power_off_pin,
  input wire logic tx_ready,
  // Outputs
  input wire logic close_ack,
  input wire logic digital_audio_test_port,
  input wire logic tx_valid,
  input wire tcl_pkg::tcl_tx_s tx,
  input wire logic loop_closed,
  input wire logic loop_running,
  input wire tcl_pkg::tcl_loop_e loop_type,
  input wire logic test_card
);
  logic [7:0] fr_q;
  logic [7:0] fr_d;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Frames spent closed but not yet running
  always_comb begin
    fr_d = (loop_closed && !loop_running) ? fr_q + {7'h0, frame_tick} : 8'h0;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) fr_q <= 8'h0;
    else fr_q <= fr_d;
  end
  // Well formed command, and a state that may take it
  sequence good_cmd;
    cmd_valid && cmd.close && !cmd.open && cmd.sapi == 4'h0 && cmd.ack_mode && cmd.on_dcch;
  endsequence
  sequence may_close;
    tch_active && test_card && card_present_pin && !loop_closed && !digital_audio_test_port &&
    !$past(power_off_pin, 2);
  endsequence
  close_taken_a: assert property (good_cmd ##0 may_close |=> close_ack && loop_closed)
    else $error("close not taken");
  wrong_sap_a: assert property (cmd_valid && cmd.sapi != 4'h0 |=> !close_ack)
    else $error("close on wrong access point");
  ack_cause_a: assert property (close_ack |-> $past(tch_active) && $past(test_card))
    else $error("close without channel or card");
  no_reclose_a: assert property (loop_closed && cmd_valid |=> !close_ack)
    else $error("close while closed");
  dai_excl_a: assert property (!(loop_closed && digital_audio_test_port))
    else $error("loop and audio test together");
  setup_bound_a: assert property (fr_q <= 8'h68)
    else $error("loop not running in time");
  card_drop_a: assert property (!card_present_pin [*4] |-> !loop_closed && !test_card)
    else $error("loop kept after card removal");
  burst_form_a: assert property (tx_valid && loop_running && loop_type == tcl_pkg::LOOP_C
    |-> tx.nbits == `TCL_LEN_BURST && tx.own_midamble && tx.bits[259:114] == '0)
    else $error("bad burst format");
  // Stall keeps the word
  tx_hold_a: assert property (tx_valid && !tx_ready && loop_running |=> tx_valid && $stable(tx))
    else $error("uplink word lost in stall");
endmodule
bind tcl_test_loop tcl_test_loop_props chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
  .cmd_valid(cmd_valid), .cmd(cmd), .tch_active(tch_active), .frame_tick(frame_tick),
  .card_present_pin(card_present_pin), .power_off_pin(power_off_pin), .tx_ready(tx_ready),
  .close_ack(close_ack),
  .digital_audio_test_port(digital_audio_test_port), .tx_valid(tx_valid), .tx(tx),
  .loop_closed(loop_closed), .loop_running(loop_running), .loop_type(loop_type),
  .test_card(test_card));

// file: testbench/tcl_sim_model.sv
// System simulator model: sends test commands, drains the uplink.
// Assumes the bench clock; changes its lines on the falling edge.
`timescale 1ns/1ps
module tcl_sim_model (
  // Clock
  input wire logic clk_sys,
  // Command side
  output logic cmd_valid,
  output tcl_pkg::tcl_cmd_s cmd,
  // Uplink side
  input wire logic tx_valid,
  input wire tcl_pkg::tcl_tx_s tx,
  output logic tx_ready
);
  // Idle, stalling uplink
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
    tx_ready = 1'b0;
  end
  // One command pulse, dedicated channel, acknowledged mode
  task automatic send(input logic cl, input logic op, input tcl_pkg::tcl_loop_e lt,
      input logic [3:0] sp);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd = '{cl, op, lt, sp, 1'b1, 1'b1};
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    cmd = ~cmd; // Released lines do not hold
  endtask
  // Accept exactly one uplink word
  task automatic take(output tcl_pkg::tcl_tx_s w);
    @(negedge clk_sys);
    while (tx_valid !== 1'b1) @(negedge clk_sys);
    w = tx;
    tx_ready = 1'b1;
    @(negedge clk_sys);
    tx_ready = 1'b0;
  endtask
endmodule

// file: testbench/traffic_channel_test_loop_bench.sv
// Bench of the test loop: card gating, commands, all loop types, buffer.
// Assumes frame ticks every 8 clocks made here; partner in tcl_sim_model.
`timescale 1ns/1ps
`include "tcl_cfg.svh"
module traffic_channel_test_loop_bench;
  logic clk_sys, rst_n, cmd_valid, close_ack, tch_active, frame_tick, card_present_pin;
  logic admin_valid, dai_req, digital_audio_test_port, rx_valid, rx_ready, tx_valid;
  logic tx_ready, loop_closed, loop_running, test_card, rtd_overrun, power_off_pin;
  logic [7:0] admin_data;
  tcl_pkg::tcl_cmd_s cmd;
  tcl_pkg::tcl_rx_s rx, r;
  tcl_pkg::tcl_tx_s tx;
  tcl_pkg::tcl_loop_e loop_type;
  int n_errors = 0;
  int num_checks = 0;
  tcl_test_loop dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
    .close_ack(close_ack), .tch_active(tch_active), .frame_tick(frame_tick),
    .card_present_pin(card_present_pin), .power_off_pin(power_off_pin),
    .admin_valid(admin_valid),
    .admin_data(admin_data), .dai_req(dai_req),
    .digital_audio_test_port(digital_audio_test_port), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx(rx), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx(tx),
    .loop_closed(loop_closed), .loop_running(loop_running), .loop_type(loop_type),
    .test_card(test_card), .rtd_overrun(rtd_overrun));
  tcl_sim_model sim_u (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd(cmd),
    .tx_valid(tx_valid), .tx(tx), .tx_ready(tx_ready));
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Frame tick every 8 clocks
  initial begin
    frame_tick = 1'b0;
    forever begin
      repeat (7) @(negedge clk_sys);
      frame_tick = 1'b1;
      @(negedge clk_sys);
      frame_tick = 1'b0;
    end
  end
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [299:0] s, input logic [299:0] x);
    num_checks++;
    if (s !== x) begin
      n_errors++;
      $display("FAIL %s exp %h seen %h", n, x, s);
    end
  endtask
  // Downlink word: present, wait ready, release
  task automatic pre(input tcl_pkg::tcl_rx_s v);
    @(negedge clk_sys);
    rx_valid = 1'b1;
    rx = v;
    #1;
  endtask
  task automatic fin;
    while (rx_ready !== 1'b1) begin
      @(negedge clk_sys);
      #1;
    end
    @(negedge clk_sys);
    rx_valid = 1'b0;
    rx = ~rx;
  endtask
  task automatic put(input tcl_pkg::tcl_rx_s v);
    pre(v);
    fin();
  endtask
  task automatic get(input string n, input tcl_pkg::tcl_tx_s x);
    tcl_pkg::tcl_tx_s w;
    sim_u.take(w);
    chk(n, w, x);
  endtask
  task automatic admin(input logic [7:0] d);
    @(negedge clk_sys);
    admin_valid = 1'b1;
    admin_data = d;
    @(negedge clk_sys);
    admin_valid = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic close_loop(input tcl_pkg::tcl_loop_e lt);
    sim_u.send(1'b1, 1'b0, lt, 4'h0);
    chk("close_ack", close_ack, 1'b1);
    chk("loop_type", loop_type, lt);
    while (loop_running !== 1'b1) @(negedge clk_sys);
  endtask
  task automatic open_loop;
    sim_u.send(1'b0, 1'b1, tcl_pkg::LOOP_A, 4'h0);
    chk("loop_closed", loop_closed, 1'b0);
  endtask
  task automatic t_card;
    admin(8'h01);
    chk("test_card", test_card, 1'b0);
    sim_u.send(1'b1, 1'b0, tcl_pkg::LOOP_A, 4'h0);
    chk("close_ack", close_ack, 1'b0);
    admin(`TCL_ADMIN_TEST);
    chk("test_card", test_card, 1'b1);
  endtask
  task automatic t_tch;
    tch_active = 1'b0;
    sim_u.send(1'b1, 1'b0, tcl_pkg::LOOP_A, 4'h0);
    chk("close_ack", close_ack, 1'b0);
    tch_active = 1'b1;
  endtask
  task automatic t_loop_a;
    sim_u.send(1'b1, 1'b0, tcl_pkg::LOOP_A, 4'h1);
    chk("close_ack", close_ack, 1'b0);
    close_loop(tcl_pkg::LOOP_A);
    sim_u.send(1'b1, 1'b0, tcl_pkg::LOOP_B, 4'h0);
    chk("close_ack", close_ack, 1'b0);
    r = '0;
    r.bfi = 1'b1;
    r.bits = '1;
    put(r);
    get("zero", '{1'b0, 1'b0, `TCL_LEN_FRAME, 260'h0});
    open_loop();
  endtask
  task automatic t_loop_b;
    close_loop(tcl_pkg::LOOP_B);
    r = '0;
    r.efr = 1'b1;
    r.bits = '1;
    put(r);
    get("efr", '{1'b0, 1'b0, `TCL_LEN_EFR, {16'h0, {244{1'b1}}}});
    open_loop();
  endtask
  // Control burst dropped, bad midamble kept, buffer filled while stalled
  task automatic t_loop_c;
    close_loop(tcl_pkg::LOOP_C);
    r = '0;
    r.is_burst = 1'b1;
    r.kind = tcl_pkg::BURST_SACCH;
    put(r);
    r.kind = tcl_pkg::BURST_TCH;
    r.bits = '1;
    put(r);
    put(r);
    pre(r);
    chk("rx_ready", rx_ready, 1'b0);
    fork
      fin();
      repeat (3) get("burst", '{1'b1, 1'b1, `TCL_LEN_BURST, {146'h0, {114{1'b1}}}});
    join
    chk("rtd_overrun", rtd_overrun, 1'b0);
    // A burst left waiting past the round-trip bound raises the flag
    put(r);
    repeat (224) @(negedge clk_sys);
    chk("rtd_overrun", rtd_overrun, 1'b1);
    get("late", '{1'b1, 1'b1, `TCL_LEN_BURST, {146'h0, {114{1'b1}}}});
    open_loop();
  endtask
  task automatic t_modes;
    for (int i = 3; i < 6; i++) begin
      close_loop(tcl_pkg::tcl_loop_e'(i));
      r = '0;
      r.sid = `TCL_SID_VALID;
      r.bits = '1;
      put(r);
      get("kept", '{1'b0, 1'b0, `TCL_LEN_FRAME, {260{1'b1}}});
      r.ufi = (i == 3);
      r.sid = (i == 3) ? `TCL_SID_VALID : 2'(i - 4);
      put(r);
      get("erased", '{1'b0, 1'b0, `TCL_LEN_FRAME, 260'h0});
      open_loop();
    end
  endtask
  task automatic t_dai;
    close_loop(tcl_pkg::LOOP_A);
    dai_req = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("dai", digital_audio_test_port, 1'b0);
    open_loop();
    @(negedge clk_sys);
    chk("dai", digital_audio_test_port, 1'b1);
    sim_u.send(1'b1, 1'b0, tcl_pkg::LOOP_A, 4'h0);
    chk("close_ack", close_ack, 1'b0);
    dai_req = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic t_power;
    close_loop(tcl_pkg::LOOP_D);
    power_off_pin = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("loop_closed", loop_closed, 1'b0);
    sim_u.send(1'b1, 1'b0, tcl_pkg::LOOP_A, 4'h0);
    chk("close_ack", close_ack, 1'b0);
    power_off_pin = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic t_drop;
    close_loop(tcl_pkg::LOOP_E);
    chk("rtd_overrun", rtd_overrun, 1'b0);
    card_present_pin = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk("loop_closed", loop_closed, 1'b0);
    chk("test_card", test_card, 1'b0);
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0;
    tch_active = 1'b1;
    card_present_pin = 1'b1;
    power_off_pin = 1'b0;
    admin_valid = 1'b0;
    admin_data = 8'h00;
    dai_req = 1'b0;
    rx_valid = 1'b0;
    rx = '0;
    r = '0;
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    t_card();
    t_tch();
    t_loop_a();
    t_loop_b();
    t_loop_c();
    t_modes();
    t_dai();
    t_power();
    t_drop();
    give_verdict();
  end
  // Watchdog
  initial begin
    #2000000;
    n_errors++;
    give_verdict();
  end
endmodule
